// ---- common/qio_consts.svh ----
// Constants of the quasi-bidirectional I/O expander
`ifndef QIO_CONSTS_SVH
`define QIO_CONSTS_SVH
`define QIO_PREFIX_BASE 4'h4
`define QIO_PREFIX_ALT 4'h7
`define QIO_LATCH_RST 8'hff
`define QIO_PIN_RST 8'hff
`define QIO_BITS 4'h8
`define QIO_CNT_ZERO 4'h0
`define QIO_CNT_ONE 4'h1
`define QIO_MSB 3'h7
`define QIO_IDLE_HI 1'b1
`endif

// ---- common/qio_pkg.sv ----
// Types shared by the I/O expander modules
package qio_pkg;
  typedef logic [7:0] qio_byte_t;
  typedef logic [2:0] qio_strap_t;
  typedef enum logic [2:0] {
    QIO_IDLE = 3'b000,
    QIO_ADDR = 3'b001,
    QIO_ADDR_ACK = 3'b010,
    QIO_WR_DATA = 3'b011,
    QIO_WR_ACK = 3'b100,
    QIO_RD_DATA = 3'b101,
    QIO_RD_ACK = 3'b110
  } qio_state_t;
endpackage : qio_pkg

// ---- common/qio_sync_if.sv ----
// Synchronised bus events and pin samples
interface qio_sync_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start;
  logic stop;
  qio_pkg::qio_byte_t pins;
  qio_pkg::qio_strap_t strap;
  modport src (output scl_rise, scl_fall, sda, start, stop, pins, strap);
  modport dst (input scl_rise, scl_fall, sda, start, stop, pins, strap);
endinterface : qio_sync_if

// ---- hw/qio_sync.sv ----
// Input synchronisers and bus condition detection
`include "qio_consts.svh"
module qio_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw inputs
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] pins_i,
  input wire logic [2:0] strap_i,
  // Synchronised view
  qio_sync_if.src sy
);
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic [7:0] pin_m_q, pin_s_q;
  logic [2:0] strap_m_q, strap_s_q;

  // Two-flop synchronisers, idle high except the straps, which reset to zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_m_q <= `QIO_IDLE_HI;
      scl_s_q <= `QIO_IDLE_HI;
      sda_m_q <= `QIO_IDLE_HI;
      sda_s_q <= `QIO_IDLE_HI;
      pin_m_q <= `QIO_PIN_RST;
      pin_s_q <= `QIO_PIN_RST;
      strap_m_q <= '0;
      strap_s_q <= '0;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      pin_m_q <= pins_i;
      pin_s_q <= pin_m_q;
      strap_m_q <= strap_i;
      strap_s_q <= strap_m_q;
    end
  end

  // Previous synchronised levels for edge finding
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_p_q <= `QIO_IDLE_HI;
      sda_p_q <= `QIO_IDLE_HI;
    end else begin
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Clock edges, START and STOP from synchronised samples
  assign sy.scl_rise = scl_s_q & ~scl_p_q;
  assign sy.scl_fall = ~scl_s_q & scl_p_q;
  assign sy.start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign sy.stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign sy.sda = sda_s_q;
  assign sy.pins = pin_s_q;
  assign sy.strap = strap_s_q;
endmodule : qio_sync

// ---- hw/qio_expander.sv ----
// Eight-bit quasi-bidirectional port expander, serial bus target
`include "qio_consts.svh"
module qio_expander #(
  parameter bit ALT_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Serial bus
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // Address straps
  input wire logic [2:0] ADDR_STRAP,
  // Quasi-bidirectional port
  input wire logic [7:0] PORT_PIN_I,
  output logic [7:0] PORT_PIN_O,
  output logic [7:0] PORT_PIN_OE,
  // Open-drain interrupt
  output logic INT_O,
  output logic INT_OE
);
  qio_sync_if sy ();
  qio_pkg::qio_state_t state_q;
  logic [3:0] cnt_q;
  qio_pkg::qio_byte_t shift_q, latch_q, strong_q, snap_q;
  logic rw_q, nack_q, sda_oe_q, int_oe_q;
  logic [7:0] port_oe_q, port_o_q;
  logic addr_hit;

  qio_sync u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .pins_i(PORT_PIN_I),
    .strap_i(ADDR_STRAP),
    .sy(sy)
  );

  // Shift one sampled bit into the byte, MSB first
  function automatic qio_pkg::qio_byte_t shl(
    input qio_pkg::qio_byte_t b, input logic d);
    shl = {b[6:0], d};
  endfunction : shl

  // Address byte match against prefix and straps
  function automatic logic match(input qio_pkg::qio_byte_t b,
                                 input qio_pkg::qio_strap_t s);
    logic [3:0] pre;
    pre = ALT_VARIANT ? `QIO_PREFIX_ALT : `QIO_PREFIX_BASE;
    match = (b[7:4] == pre) && (b[3:1] == s);
  endfunction : match

  assign addr_hit = match(shift_q, sy.strap);

  // Bus protocol sequencer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= qio_pkg::QIO_IDLE;
      cnt_q <= `QIO_CNT_ZERO;
      shift_q <= '0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (sy.start) begin
      state_q <= qio_pkg::QIO_ADDR; // Repeated START too
      cnt_q <= `QIO_CNT_ZERO;
      sda_oe_q <= 1'b0;
    end else if (sy.stop) begin
      state_q <= qio_pkg::QIO_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        qio_pkg::QIO_ADDR: begin
          if (sy.scl_rise) begin
            shift_q <= shl(shift_q, sy.sda);
            cnt_q <= cnt_q + `QIO_CNT_ONE;
          end else if (sy.scl_fall && cnt_q == `QIO_BITS) begin
            if (addr_hit) begin
              state_q <= qio_pkg::QIO_ADDR_ACK;
              rw_q <= shift_q[0];
              sda_oe_q <= 1'b1;
            end else begin
              state_q <= qio_pkg::QIO_IDLE;
            end
          end
        end
        qio_pkg::QIO_ADDR_ACK: begin
          if (sy.scl_fall) begin
            cnt_q <= `QIO_CNT_ZERO;
            if (rw_q) begin
              state_q <= qio_pkg::QIO_RD_DATA;
              shift_q <= sy.pins; // Live pins
              sda_oe_q <= ~sy.pins[`QIO_MSB];
            end else begin
              state_q <= qio_pkg::QIO_WR_DATA; // No command byte
              sda_oe_q <= 1'b0;
            end
          end
        end
        qio_pkg::QIO_WR_DATA: begin
          if (sy.scl_rise) begin
            shift_q <= shl(shift_q, sy.sda);
            cnt_q <= cnt_q + `QIO_CNT_ONE;
          end else if (sy.scl_fall && cnt_q == `QIO_BITS) begin
            state_q <= qio_pkg::QIO_WR_ACK;
            sda_oe_q <= 1'b1;
          end
        end
        qio_pkg::QIO_WR_ACK: begin
          if (sy.scl_fall) begin
            state_q <= qio_pkg::QIO_WR_DATA; // Unlimited bytes
            cnt_q <= `QIO_CNT_ZERO;
            sda_oe_q <= 1'b0;
          end
        end
        qio_pkg::QIO_RD_DATA: begin
          if (sy.scl_rise) begin
            cnt_q <= cnt_q + `QIO_CNT_ONE;
          end else if (sy.scl_fall) begin
            if (cnt_q == `QIO_BITS) begin
              state_q <= qio_pkg::QIO_RD_ACK;
              sda_oe_q <= 1'b0;
            end else begin
              sda_oe_q <= ~shift_q[`QIO_MSB - cnt_q[2:0]];
            end
          end
        end
        qio_pkg::QIO_RD_ACK: begin
          if (sy.scl_rise) begin
            nack_q <= sy.sda;
          end else if (sy.scl_fall) begin
            cnt_q <= `QIO_CNT_ZERO;
            if (nack_q) begin
              state_q <= qio_pkg::QIO_IDLE;
            end else begin
              state_q <= qio_pkg::QIO_RD_DATA; // Resample pins
              shift_q <= sy.pins;
              sda_oe_q <= ~sy.pins[`QIO_MSB];
            end
          end
        end
        default: begin
          state_q <= qio_pkg::QIO_IDLE;
        end
      endcase
    end
  end

  // Port latch and ack-time strong pull-up, all bits alike
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      latch_q <= `QIO_LATCH_RST;
      strong_q <= '0;
    end else if (state_q == qio_pkg::QIO_WR_ACK && sy.scl_rise) begin
      latch_q <= shift_q; // Bit n drives pin n
      strong_q <= shift_q;
    end else if (state_q != qio_pkg::QIO_WR_ACK || sy.scl_fall) begin
      strong_q <= '0; // Weak pull-up only afterwards
    end
  end

  // Change detection against the last accessed port state
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      snap_q <= `QIO_PIN_RST;
      int_oe_q <= 1'b0;
    end else begin
      // Write snaps at ack fall, once the new latch shows on the pins
      if ((state_q == qio_pkg::QIO_WR_ACK && sy.scl_fall) ||
          (state_q == qio_pkg::QIO_ADDR_ACK && rw_q && sy.scl_rise)) begin
        snap_q <= sy.pins; // Access clears
      end
      int_oe_q <= (sy.pins != snap_q);
    end
  end

  // Registered pin drivers: sink for 0, strong high during ack
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      port_oe_q <= '0;
      port_o_q <= '0;
    end else begin
      port_oe_q <= ~latch_q | strong_q;
      port_o_q <= strong_q;
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE = sda_oe_q;
  assign PORT_PIN_O = port_o_q;
  assign PORT_PIN_OE = port_oe_q;
  assign INT_O = 1'b0;
  assign INT_OE = int_oe_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_addr_done;
    state_q == qio_pkg::QIO_ADDR && sy.scl_fall && cnt_q == `QIO_BITS
      && !sy.start && !sy.stop;
  endsequence
  sequence s_rd_enter;
    state_q == qio_pkg::QIO_ADDR_ACK && sy.scl_fall && rw_q
      && !sy.start && !sy.stop;
  endsequence
  sequence s_wr_ack_rise;
    state_q == qio_pkg::QIO_WR_ACK && sy.scl_rise && !sy.start && !sy.stop;
  endsequence

  property p_addr_miss;
    s_addr_done ##0 !addr_hit |=> state_q == qio_pkg::QIO_IDLE && !sda_oe_q;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("unmatched address was acknowledged");
  property p_addr_hit;
    s_addr_done ##0 addr_hit |=> sda_oe_q && rw_q == $past(shift_q[0]);
  endproperty
  a_addr_hit: assert property (p_addr_hit)
    else $error("matching address not acknowledged");
  property p_read_dir;
    s_rd_enter |=> state_q == qio_pkg::QIO_RD_DATA;
  endproperty
  a_read_dir: assert property (p_read_dir)
    else $error("read bit did not select read transfer");
  property p_read_pins;
    s_rd_enter |=> shift_q == $past(sy.pins) && sda_oe_q == !shift_q[7];
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("read byte is not the pin levels");
  property p_write_latch;
    s_wr_ack_rise |=> latch_q == $past(shift_q) ##1 port_oe_q[0] ==
      (!latch_q[0] || strong_q[0]);
  endproperty
  a_write_latch: assert property (p_write_latch)
    else $error("acknowledged byte not latched");
  property p_strong_ack;
    strong_q != '0 |-> state_q == qio_pkg::QIO_WR_ACK;
  endproperty
  a_strong_ack: assert property (p_strong_ack)
    else $error("strong pull-up outside acknowledge");
  property p_sink;
    (latch_q == $past(latch_q)) |=> (~$past(latch_q, 2) & ~port_oe_q) == '0;
  endproperty
  a_sink: assert property (p_sink)
    else $error("written zero not sunk");
  property p_int_set;
    (sy.pins != snap_q) |=> int_oe_q;
  endproperty
  a_int_set: assert property (p_int_set)
    else $error("pin change did not raise interrupt");
  property p_int_clear;
    (sy.pins == snap_q) |=> !int_oe_q;
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt held with no change");
  property p_nack_end;
    state_q == qio_pkg::QIO_RD_ACK && sy.scl_fall && nack_q && !sy.start
      && !sy.stop |=> state_q == qio_pkg::QIO_IDLE && !sda_oe_q;
  endproperty
  a_nack_end: assert property (p_nack_end)
    else $error("read continued after not-acknowledge");
endmodule : qio_expander

// ---- sim/qio_ctrl_model.sv ----
// Serial bus controller model that drives the expander
module qio_ctrl_model (
  // Clock
  input wire logic clk,
  // Bus lines, data is open drain (1 releases)
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Wait falling system clock edges
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  // START, also usable as repeated START
  task automatic start();
    w(2);
    sda_drv = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    sda_drv = 1'b0;
    w(4);
    scl = 1'b0;
  endtask : start
  // One bit out, data set mid low phase
  task automatic bit_out(input logic b);
    w(2);
    sda_drv = b;
    w(2);
    scl = 1'b1;
    w(4);
    scl = 1'b0;
  endtask : bit_out
  // One bit in, sampled at the end of the high phase
  task automatic bit_in(output logic b);
    w(2);
    sda_drv = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    b = sda;
    scl = 1'b0;
  endtask : bit_in
  // Byte out MSB first; ack is 1 when the target pulled low
  task automatic send_byte(input qio_pkg::qio_byte_t d,
                           output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask : send_byte
  // Byte in MSB first, then ACK or NACK
  task automatic recv_byte(input logic give_ack,
                           output qio_pkg::qio_byte_t d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(~give_ack);
  endtask : recv_byte
  // STOP: data rises while clock high
  task automatic stop();
    w(2);
    sda_drv = 1'b0;
    w(2);
    scl = 1'b1;
    w(4);
    sda_drv = 1'b1;
    w(4);
  endtask : stop
endmodule : qio_ctrl_model

// ---- sim/qio_expander_tb.sv ----
// Self-checking bench for the quasi-bidirectional expander
`include "qio_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module qio_expander_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, sda_oe, int_oe, ack;
  wire logic scl, sda_drv, sda;
  logic [2:0] strap;
  qio_pkg::qio_byte_t ext, pins, pin_o, pin_oe, d, snap_oe, snap_o;
  int mismatches = 0;
  int comparisons = 0;
  // Open-drain bus with pull-up; pins follow ext unless driven
  assign sda = sda_drv & ~sda_oe;
  assign pins = (pin_oe & pin_o) | (~pin_oe & ext);
  // Design and bus controller
  qio_expander #(.ALT_VARIANT(1'b0)) DUT (.CLK(clk), .ARST_N(arst_n),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe),
    .ADDR_STRAP(strap), .PORT_PIN_I(pins), .PORT_PIN_O(pin_o),
    .PORT_PIN_OE(pin_oe), .INT_O(), .INT_OE(int_oe));
  qio_ctrl_model CTL (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Verdict
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // Address byte after START
  task automatic addr(input logic [3:0] pre, input logic [2:0] s,
                      input logic rw);
    CTL.start();
    CTL.send_byte({pre, s, rw}, ack);
  endtask : addr
  // Data byte with a look at the pin drivers one clock after the acknowledge clock falls
  task automatic wr_byte(input qio_pkg::qio_byte_t b);
    fork
      CTL.send_byte(b, ack);
      begin
        repeat (9) @(posedge scl);
        @(negedge scl);
        @(negedge clk);
        snap_oe = pin_oe;
        snap_o = pin_o;
      end
    join
    `CHK(ack, 1'b1)
    `CHK(snap_oe, 8'hff)
    `CHK(snap_o, b)
    CTL.w(8);
    `CHK(pin_oe, ~b)
    `CHK(pins, b)
    `CHK(int_oe, 1'b0)
  endtask : wr_byte
  // Reset state: weak-high pins, read returns all ones
  task automatic t_reset();
    `CHK(pin_oe, 8'h00)
    `CHK(sda_oe, 1'b0)
    `CHK(int_oe, 1'b0)
    addr(`QIO_PREFIX_BASE, strap, 1'b1);
    CTL.recv_byte(1'b0, d);
    CTL.stop();
    `CHK(d, `QIO_LATCH_RST)
  endtask : t_reset
  // Every strap setting: match, wrong prefix, wrong strap bits
  task automatic t_addr();
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      CTL.w(4);
      addr(`QIO_PREFIX_BASE, strap, 1'b0);
      CTL.stop();
      `CHK(ack, 1'b1)
      addr(`QIO_PREFIX_ALT, strap, 1'b0);
      CTL.stop();
      `CHK(ack, 1'b0)
      addr(`QIO_PREFIX_BASE, ~strap, 1'b0);
      CTL.stop();
      `CHK(ack, 1'b0)
    end
  endtask : t_addr
  // Back-to-back data bytes overwrite the latch
  task automatic t_write();
    addr(`QIO_PREFIX_BASE, strap, 1'b0);
    `CHK(ack, 1'b1)
    wr_byte(8'ha5);
    wr_byte(8'h3c);
    wr_byte(8'h00);
    CTL.stop();
  endtask : t_write
  // Read returns pin levels, repeats on ACK, interrupt follows pins
  task automatic t_read();
    addr(`QIO_PREFIX_BASE, strap, 1'b0);
    wr_byte(8'hf0); // Upper pins become inputs
    CTL.stop();
    ext = 8'h7f;
    CTL.w(8);
    `CHK(int_oe, 1'b1)
    addr(`QIO_PREFIX_BASE, strap, 1'b1);
    `CHK(ack, 1'b1)
    CTL.w(6);
    `CHK(int_oe, 1'b0)
    ext = 8'hef;
    CTL.recv_byte(1'b1, d);
    `CHK(d, 8'h70)
    CTL.recv_byte(1'b0, d);
    `CHK(d, 8'he0)
    CTL.stop();
    `CHK(sda_oe, 1'b0)
    `CHK(int_oe, 1'b1)
    ext = 8'h7f;
    CTL.w(8);
    `CHK(int_oe, 1'b0)
  endtask : t_read
  // Main sequence
  initial begin
    arst_n = 1'b0;
    strap = 3'h0;
    ext = 8'hff;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    CTL.w(8);
    t_reset();
    t_addr();
    t_write();
    t_read();
    end_sim();
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : qio_expander_tb
